//--- diag_monitor_readback_regs.sv
`timescale 1ns/1ps
module diag_monitor_readback_regs (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RST_I,
    // AHB-Lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Monitor converter results
    input diag_mon_pkg::mon_sample_s MON_SAMPLE_I,
    // Freeze level toward the converter
    output logic FREEZE_RESULT_UPDATE_O
);
    import diag_mon_pkg::*;

    reg_access_s access;
    logic [11:0] result [NUM_SOURCES];
    logic [NUM_SOURCES-1:0] updated;
    logic [7:0] hold_cfg_q;
    logic [7:0] hold_cfg_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic freeze;
    logic sample_dropped;
    logic status_read;

    // Identifier of each slot, in slot order
    localparam logic [3:0] SLOT_ID [NUM_SOURCES] = '{
        ID_BATTERY,
        ID_MIC_SUPPLY,
        ID_CH1_POS,
        ID_CH1_NEG,
        ID_CH2_POS
    };

    // Upper result byte of one slot
    function automatic logic [7:0] high_byte(input logic [11:0] value);
        high_byte = value[HIGH_MSB:HIGH_LSB];
    endfunction

    // Companion byte: low result nibble over the fixed identifier
    function automatic logic [7:0] low_and_id(input logic [11:0] value, input logic [3:0] id);
        low_and_id = {value[LOW_MSB:0], id};
    endfunction

    // Bus front-end decodes address and data phases
    ahb_reg_port u_port (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .hsel_i(HSEL_I),
        .haddr_i(HADDR_I),
        .htrans_i(HTRANS_I),
        .hwrite_i(HWRITE_I),
        .hready_i(HREADY_I),
        .access_o(access)
    );

    // Hold bit steers every slot
    assign freeze = hold_cfg_q[HOLD_BIT];
    assign FREEZE_RESULT_UPDATE_O = hold_cfg_q[HOLD_BIT];

    // One storage slot per monitored source
    for (genvar s = 0; s < NUM_SOURCES; s++) begin : g_slot
        result_slot #(
            .SOURCE_ID(SLOT_ID[s])
        ) u_slot (
            .clk_i(MCLK_I),
            .rst_i(RST_I),
            .sample_i(MON_SAMPLE_I),
            .freeze_i(freeze),
            .result_o(result[s]),
            .updated_o(updated[s])
        );
    end

    // Sample addressed to a held slot is lost
    always_comb begin
        sample_dropped = 1'b0;
        for (int s = 0; s < NUM_SOURCES; s++) begin
            if (MON_SAMPLE_I.valid && MON_SAMPLE_I.source == SLOT_ID[s] && freeze) begin
                sample_dropped = 1'b1;
            end
        end
    end

    // Hold configuration: only the hold bit and the spare nibble are writable
    always_comb begin
        hold_cfg_d = hold_cfg_q;
        if (access.write && access.write_mapped && access.write_index == IDX_HOLD_CFG) begin
            hold_cfg_d[HOLD_BIT] = HWDATA_I[HOLD_BIT];
            hold_cfg_d[CFG_SPARE_MSB:CFG_SPARE_LSB] = HWDATA_I[CFG_SPARE_MSB:CFG_SPARE_LSB];
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            hold_cfg_q <= HOLD_CFG_RESET;
        end else begin
            hold_cfg_q <= hold_cfg_d;
        end
    end

    // Update status: sticky, cleared by a read, a new event wins over the clear
    assign status_read = access.read && access.mapped && access.index == IDX_UPDATE_STATUS;
    always_comb begin
        status_d = status_q;
        if (status_read) begin
            status_d = UPDATE_STATUS_RESET;
        end
        status_d[NUM_SOURCES-1:0] = status_d[NUM_SOURCES-1:0] | updated;
        if (sample_dropped) begin
            status_d[DROPPED_BIT] = 1'b1;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            status_q <= UPDATE_STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // Read data taken at the address phase, shown in the data phase
    always_comb begin
        hrdata_d = hrdata_q;
        if (access.read) begin
            hrdata_d = 32'h0000_0000;
            if (!access.mapped) begin
                hrdata_d = 32'h0000_0000;
            end else if (access.index == IDX_HOLD_CFG) begin
                // Forwarded so a read right behind a write sees the new value
                hrdata_d[7:0] = hold_cfg_d;
            end else if (access.index == IDX_UPDATE_STATUS) begin
                hrdata_d[7:0] = status_q;
            end else if (access.index == IDX_BAT_HIGH) begin
                hrdata_d[7:0] = high_byte(result[0]);
            end else if (access.index == IDX_BAT_LOW) begin
                hrdata_d[7:0] = low_and_id(result[0], ID_BATTERY);
            end else if (access.index == IDX_MIC_HIGH) begin
                hrdata_d[7:0] = high_byte(result[1]);
            end else if (access.index == IDX_MIC_LOW) begin
                hrdata_d[7:0] = low_and_id(result[1], ID_MIC_SUPPLY);
            end else if (access.index == IDX_CH1P_HIGH) begin
                hrdata_d[7:0] = high_byte(result[2]);
            end else if (access.index == IDX_CH1P_LOW) begin
                hrdata_d[7:0] = low_and_id(result[2], ID_CH1_POS);
            end else if (access.index == IDX_CH1N_HIGH) begin
                hrdata_d[7:0] = high_byte(result[3]);
            end else if (access.index == IDX_CH1N_LOW) begin
                hrdata_d[7:0] = low_and_id(result[3], ID_CH1_NEG);
            end else if (access.index == IDX_CH2P_HIGH) begin
                hrdata_d[7:0] = high_byte(result[4]);
            end else if (access.index == IDX_CH2P_LOW) begin
                hrdata_d[7:0] = low_and_id(result[4], ID_CH2_POS);
            end else begin
                hrdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            hrdata_q <= 32'h0000_0000;
        end else begin
            hrdata_q <= hrdata_d;
        end
    end

    // Result slots take no bus write at all, so writes there fall away
    assign HRDATA_O = hrdata_q;
    // Zero wait states, always OKAY
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = HRESP_OKAY;

endmodule

//--- diag_mon_pkg.sv
package diag_mon_pkg;

    // Number of monitored sources held in this bank
    localparam int NUM_SOURCES = 5;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_HOLD_CFG = 8'h59;
    localparam logic [7:0] IDX_BAT_HIGH = 8'h5a;
    localparam logic [7:0] IDX_BAT_LOW = 8'h5b;
    localparam logic [7:0] IDX_MIC_HIGH = 8'h5c;
    localparam logic [7:0] IDX_MIC_LOW = 8'h5d;
    localparam logic [7:0] IDX_CH1P_HIGH = 8'h5e;
    localparam logic [7:0] IDX_CH1P_LOW = 8'h5f;
    localparam logic [7:0] IDX_CH1N_HIGH = 8'h60;
    localparam logic [7:0] IDX_CH1N_LOW = 8'h61;
    localparam logic [7:0] IDX_CH2P_HIGH = 8'h62;
    localparam logic [7:0] IDX_CH2P_LOW = 8'h63;
    localparam logic [7:0] IDX_UPDATE_STATUS = 8'h50;

    // Fixed source identifiers, low nibble of each companion register
    localparam logic [3:0] ID_BATTERY = 4'h0;
    localparam logic [3:0] ID_MIC_SUPPLY = 4'h1;
    localparam logic [3:0] ID_CH1_POS = 4'h2;
    localparam logic [3:0] ID_CH1_NEG = 4'h3;
    localparam logic [3:0] ID_CH2_POS = 4'h4;

    // Values after reset
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [7:0] HOLD_CFG_RESET = 8'h00;
    localparam logic [7:0] UPDATE_STATUS_RESET = 8'h00;

    // Field positions
    localparam int HOLD_BIT = 0;
    localparam int CFG_SPARE_LSB = 4;
    localparam int CFG_SPARE_MSB = 7;
    localparam int DROPPED_BIT = 7;
    localparam int HIGH_MSB = 11;
    localparam int HIGH_LSB = 4;
    localparam int LOW_MSB = 3;

    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;
    localparam logic HRESP_OKAY = 1'b0;
    localparam int ADDR_INDEX_LSB = 2;
    localparam int ADDR_INDEX_MSB = 9;

    // One finished conversion from the monitor converter
    typedef struct packed {
        logic valid;
        logic [3:0] source;
        logic [11:0] result;
    } mon_sample_s;

    // One register access decoded from the bus; a read and a write data phase may meet
    typedef struct packed {
        logic read;
        logic write;
        logic mapped;
        logic [7:0] index;
        logic write_mapped;
        logic [7:0] write_index;
    } reg_access_s;

    // Bus front-end phase
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_WRITE = 2'b10
    } bus_state_e;

    // Byte address mapped check only, the index is cut elsewhere; unmapped when misaligned or out of range
    function automatic logic addr_mapped(input logic [31:0] addr);
        addr_mapped = (addr[1:0] == 2'b00) && (addr[31:ADDR_INDEX_MSB + 1] == '0);
    endfunction

endpackage

//--- ahb_reg_port.sv
`timescale 1ns/1ps
module ahb_reg_port (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus address phase
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    // Decoded access
    output diag_mon_pkg::reg_access_s access_o
);
    import diag_mon_pkg::*;

    bus_state_e state_q;
    bus_state_e state_d;
    logic [7:0] index_q;
    logic [7:0] index_d;
    logic mapped_q;
    logic mapped_d;
    logic take;

    // Address phase taken when selected, active and bus ready
    assign take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);

    // Reads act in the address phase, writes in the following data phase
    // Write keeps its own index so a read taken in its data phase cannot cancel it
    always_comb begin
        state_d = BUS_IDLE;
        index_d = index_q;
        mapped_d = mapped_q;
        access_o = '0;
        case (state_q)
            BUS_IDLE: ;
            BUS_WRITE: begin
                access_o.write = 1'b1;
                access_o.write_mapped = mapped_q;
                access_o.write_index = index_q;
            end
            default: ;
        endcase
        if (take) begin
            index_d = haddr_i[ADDR_INDEX_MSB:ADDR_INDEX_LSB];
            mapped_d = addr_mapped(haddr_i);
            if (hwrite_i) begin
                state_d = BUS_WRITE;
            end else begin
                access_o.read = 1'b1;
                access_o.mapped = mapped_d;
                access_o.index = index_d;
            end
        end
    end

    // Phase registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= BUS_IDLE;
            index_q <= 8'h00;
            mapped_q <= 1'b0;
        end else begin
            state_q <= state_d;
            index_q <= index_d;
            mapped_q <= mapped_d;
        end
    end

endmodule

//--- result_slot.sv
`timescale 1ns/1ps
module result_slot #(
    parameter logic [3:0] SOURCE_ID = 4'h0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Converter result and freeze control
    input diag_mon_pkg::mon_sample_s sample_i,
    input wire logic freeze_i,
    // Stored result
    output logic [11:0] result_o,
    output logic updated_o
);
    import diag_mon_pkg::*;

    logic [11:0] result_q;
    logic [11:0] result_d;
    logic hit;

    // Whole 12-bit result replaced at once so both bytes stay paired
    assign hit = sample_i.valid && (sample_i.source == SOURCE_ID);
    always_comb begin
        result_d = result_q;
        updated_o = 1'b0;
        if (hit && !freeze_i) begin
            result_d = sample_i.result;
            updated_o = 1'b1;
        end
    end

    // Result storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_q <= RESULT_RESET;
        end else begin
            result_q <= result_d;
        end
    end

    assign result_o = result_q;

endmodule

//--- diag_mon_chk.sv
`timescale 1ns/1ps
module diag_mon_chk (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RST_I,
    // Bus
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    // Monitor side
    input diag_mon_pkg::mon_sample_s MON_SAMPLE_I,
    input wire logic FREEZE_RESULT_UPDATE_O
);
    import diag_mon_pkg::*;
    logic ok;
    logic rd;
    logic wr;
    logic [7:0] idx;
    logic [3:0] idn;
    logic fresh_q;
    logic fresh_d;
    default clocking dc @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    // Accesses taken at a mapped word address
    assign ok = HSEL_I && HREADY_I && HTRANS_I[1] && HADDR_I[1:0] == 2'b00 && HADDR_I[31:10] == 22'h0;
    assign rd = ok && !HWRITE_I;
    assign wr = ok && HWRITE_I;
    assign idx = HADDR_I[9:2];
    assign idn = idx[4:1] - 4'hd;
    // High until the first sample after reset
    always_comb begin
        fresh_d = RST_I || (fresh_q && !MON_SAMPLE_I.valid);
    end
    always_ff @(posedge MCLK_I) begin
        fresh_q <= fresh_d;
    end
    sequence s_smp;
        MON_SAMPLE_I.valid && MON_SAMPLE_I.source < 4'h5 && !FREEZE_RESULT_UPDATE_O;
    endsequence
    sequence s_rd_hi;
        rd && idx == IDX_BAT_HIGH + {3'h0, $past(MON_SAMPLE_I.source), 1'b0};
    endsequence
    sequence s_rd_lo;
        rd && idx == IDX_BAT_LOW + {3'h0, $past(MON_SAMPLE_I.source), 1'b0};
    endsequence
    property p_upper;
        rd |=> HRDATA_O[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits not zero");
    property p_resp;
        HRESP_O == HRESP_OKAY && HREADYOUT_O;
    endproperty
    a_resp: assert property (p_resp) else $error("response not okay");
    property p_id;
        rd && idx[0] && idx >= IDX_BAT_LOW && idx <= IDX_CH2P_LOW |=> HRDATA_O[3:0] == $past(idn);
    endproperty
    a_id: assert property (p_id) else $error("wrong source identifier");
    property p_fresh;
        rd && fresh_q && !idx[0] && idx >= IDX_BAT_HIGH && idx <= IDX_CH2P_HIGH |=> HRDATA_O == 32'h0;
    endproperty
    a_fresh: assert property (p_fresh) else $error("high byte not zero after reset");
    property p_hi;
        s_smp ##1 s_rd_hi |=> HRDATA_O[7:0] == $past(MON_SAMPLE_I.result[11:4], 2);
    endproperty
    a_hi: assert property (p_hi) else $error("high byte not the sample");
    property p_lo;
        s_smp ##1 s_rd_lo |=> HRDATA_O[7:4] == $past(MON_SAMPLE_I.result[3:0], 2);
    endproperty
    a_lo: assert property (p_lo) else $error("low nibble not the sample");
    property p_hold;
        rd && FREEZE_RESULT_UPDATE_O && idx != IDX_UPDATE_STATUS ##1 !rd ##1
            rd && FREEZE_RESULT_UPDATE_O && idx == $past(idx, 2) |=> $stable(HRDATA_O);
    endproperty
    a_hold: assert property (p_hold) else $error("held result changed");
    property p_hold_wr;
        wr && idx == IDX_HOLD_CFG |=> ##1 FREEZE_RESULT_UPDATE_O == $past(HWDATA_I[0]);
    endproperty
    a_hold_wr: assert property (p_hold_wr) else $error("freeze not the hold bit");
endmodule
bind diag_monitor_readback_regs diag_mon_chk i_chk (
    .MCLK_I(MCLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
    .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .MON_SAMPLE_I(MON_SAMPLE_I), .FREEZE_RESULT_UPDATE_O(FREEZE_RESULT_UPDATE_O)
);

//--- tb.sv
`timescale 1ns/1ps
module tb;
    import diag_mon_pkg::*;
    logic clk;
    logic rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic frz;
    logic held;
    mon_sample_s smp;
    logic [11:0] model [5];
    logic [31:0] rnd;
    logic [31:0] d0;
    logic [31:0] d1;
    logic [31:0] hold_a;
    logic [7:0] stat;
    int mismatches;
    int checks_done;
    // Device under test, hready looped back
    diag_monitor_readback_regs i_diag_monitor_readback_regs (
        .MCLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .MON_SAMPLE_I(smp), .FREEZE_RESULT_UPDATE_O(frz)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Expected register word from the result model
    function automatic logic [31:0] expv(input int i);
        logic [11:0] r;
        r = model[(i - 'h5a) / 2];
        expv = (i % 2 == 0) ? {24'h0, r[11:4]} : {24'h0, r[3:0], 4'((i - 'h5b) / 2)};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrdy();
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
    endtask
    // One single transfer; read data lands in d0, the one before moves to d1
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        wrdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wrdy();
        d1 = d0;
        d0 = hrdata;
    endtask
    task automatic rd_one(input int i);
        bus(1'b0, 32'(i * 4), 32'h0);
        bus(1'b0, 32'(i * 4), 32'h0);
        chk("result read", d1, expv(i));
        chk("result reread", d0, expv(i));
    endtask
    task automatic regs();
        for (int i = 'h5a; i <= 'h63; i++) rd_one(i);
    endtask
    // One converter result pulse
    task automatic smp_put(input logic [3:0] s, input logic [11:0] r);
        smp <= '{1'b1, s, r};
        @(posedge clk);
        smp <= '{1'b0, s, r};
        if (s < 4'h5 && !held) model[s] = r;
        if (s < 4'h5) stat[held ? 3'd7 : s[2:0]] = 1'b1;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results();
    end
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        smp = '0;
        held = 1'b0;
        stat = 8'h00;
        model = '{default: 12'h0};
        rnd = 32'h4ef0d4de;
        hold_a = {22'h0, IDX_HOLD_CFG, 2'b00};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        regs();
        $display("test reset values done");
        for (int k = 0; k < 40; k++) begin
            rnd = lfsr(rnd);
            smp_put(rnd[3:0], rnd[15:4]);
            rd_one('h5a + 2 * (int'(rnd[3:0]) % 5) + int'(rnd[20]));
            rd_one('h5a + 2 * (int'(rnd[3:0]) % 5) + int'(!rnd[20]));
        end
        $display("test random samples done");
        for (int i = 'h5a; i <= 'h63; i++) begin
            rnd = lfsr(rnd);
            bus(1'b1, 32'(i * 4), rnd);
        end
        regs();
        bus(1'b1, 32'h0000_1000, 32'h0000_00ff);
        bus(1'b0, 32'h0000_1000, 32'h0);
        chk("unmapped read", d0, 32'h0);
        $display("test write ignore done");
        bus(1'b1, hold_a, 32'h1);
        held = 1'b1;
        #1;
        chk("freeze on", {31'h0, frz}, 32'h1);
        rnd = lfsr(rnd);
        smp_put(4'h0, rnd[11:0]);
        regs();
        bus(1'b0, hold_a, 32'h0);
        chk("hold config", d0, 32'h1);
        bus(1'b1, hold_a, 32'h0);
        held = 1'b0;
        #1;
        chk("freeze off", {31'h0, frz}, 32'h0);
        rnd = lfsr(rnd);
        smp_put(4'h0, rnd[11:0]);
        regs();
        bus(1'b0, {22'h0, IDX_UPDATE_STATUS, 2'b00}, 32'h0);
        chk("update status", d0, {24'h0, stat});
        bus(1'b0, {22'h0, IDX_UPDATE_STATUS, 2'b00}, 32'h0);
        chk("status cleared", d0, 32'h0);
        $display("test hold done");
        results();
    end
endmodule
